/* File: dcil_consts.vh */
// constants for the dual channel interlock logic
// assumes inclusion by both design files of the block
`ifndef DCIL_CONSTS_VH
`define DCIL_CONSTS_VH
`define DCIL_MAX_NODES      5'h10
`define DCIL_ADDR_W         4
`define DCIL_FRAME_W        16
`define DCIL_BIT_NS         8000
`define DCIL_CLK_NS         8
`define DCIL_BIT_CYCLES     16'h03e8
`define DCIL_CMD_STATUS     4'h1
`define DCIL_CMD_TEACH      4'h2
`define DCIL_CMD_SERIAL     4'h3
`define DCIL_CMD_ACTNAME    4'h4
`define DCIL_ST_IDLE        3'h0
`define DCIL_ST_START       3'h1
`define DCIL_ST_RX          3'h2
`define DCIL_ST_EXEC        3'h3
`define DCIL_ST_TX          3'h4
`define DCIL_PL_OK          2'h0
`define DCIL_PL_UNEQ        2'h1
`define DCIL_PL_LOCK        2'h2
`define DCIL_IND_OFF        2'h0
`define DCIL_IND_ON         2'h1
`define DCIL_IND_FLASH      2'h2
`endif

/* File: dcil_diag_link.v */
// diagnostic chain link serial engine: receives frames on diag_in,
// answers on the status line; assumes diag_in already synchronised
`timescale 1ns/100ps
`include "dcil_consts.vh"
module dcil_diag_link #(
  parameter [3:0]  NODE_ADDR  = 4'h0,
  parameter [15:0] BIT_CYCLES = `DCIL_BIT_CYCLES
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        enable,
  input  wire        rx,
  input  wire [15:0] status_word,
  input  wire [15:0] teach_left,
  input  wire [15:0] serial_no,
  input  wire [15:0] actuator_name,
  output reg         tx,
  output reg         tx_active,
  output reg         name_refresh
);
  // frame: 4 bit address, 4 bit command, 8 bit spare; answer 16 bits msb first
  reg [2:0]  st_r;
  reg [15:0] cnt_r;
  reg [4:0]  bit_r;
  reg [15:0] sh_r;

  // half a bit after the start edge, so every later sample sits mid-cell, away from the synchroniser's jitter
  localparam [15:0] HALF_BIT = BIT_CYCLES / 16'h0002;

  wire       tick = (cnt_r == BIT_CYCLES - 16'h0001);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r         <= `DCIL_ST_IDLE;
      cnt_r        <= 16'h0000;
      bit_r        <= 5'h00;
      sh_r         <= 16'h0000;
      tx           <= 1'b0;
      tx_active    <= 1'b0;
      name_refresh <= 1'b0;
    end else begin
      name_refresh <= 1'b0;
      cnt_r        <= tick ? 16'h0000 : cnt_r + 16'h0001;
      if (!enable) begin
        st_r      <= `DCIL_ST_IDLE;
        tx_active <= 1'b0;
        tx        <= 1'b0;
      end else begin
        case (st_r)
          `DCIL_ST_IDLE: begin
            cnt_r <= 16'h0000;
            if (rx) begin
              st_r  <= `DCIL_ST_START;
              cnt_r <= HALF_BIT;
            end
          end
          `DCIL_ST_START: begin
            if (tick) begin
              st_r  <= `DCIL_ST_RX;
              bit_r <= 5'h00;
            end
          end
          `DCIL_ST_RX: begin
            if (tick) begin
              sh_r  <= {sh_r[14:0], rx};
              bit_r <= bit_r + 5'h01;
              if (bit_r == 5'h0f) begin
                st_r <= `DCIL_ST_EXEC;
              end
            end
          end
          `DCIL_ST_EXEC: begin
            st_r  <= `DCIL_ST_IDLE;
            bit_r <= 5'h00;
            cnt_r <= 16'h0000;
            if (sh_r[15:12] == NODE_ADDR) begin
              st_r      <= `DCIL_ST_TX;
              tx_active <= 1'b1;
              case (sh_r[11:8])
                `DCIL_CMD_STATUS:  sh_r <= status_word;
                `DCIL_CMD_TEACH:   sh_r <= teach_left;
                `DCIL_CMD_SERIAL:  sh_r <= serial_no;
                `DCIL_CMD_ACTNAME: begin
                  sh_r         <= actuator_name;
                  name_refresh <= 1'b1;
                end
                default:           sh_r <= 16'h0000;
              endcase
            end
          end
          `DCIL_ST_TX: begin
            tx <= sh_r[15];
            if (tick) begin
              sh_r  <= {sh_r[14:0], 1'b0};
              bit_r <= bit_r + 5'h01;
              if (bit_r == 5'h10) begin
                st_r      <= `DCIL_ST_IDLE;
                tx_active <= 1'b0;
                tx        <= 1'b0;
              end
            end
          end
          default: st_r <= `DCIL_ST_IDLE;
        endcase
      end
    end
  end
endmodule // dcil_diag_link

/* File: dcil_top.v */
// output and plausibility logic of a dual channel interlock sensor
// assumes actuator sense, ready and fault are same-clock levels from
// the detection front end; safety and diag pins are asynchronous
`timescale 1ns/100ps
`include "dcil_consts.vh"
module dcil_top #(
  parameter [3:0]  NODE_ADDR  = 4'h0,
  parameter [15:0] SERIAL_NO  = 16'h0001, // arbitrary value
  parameter [15:0] BIT_CYCLES = `DCIL_BIT_CYCLES
) (
  input  wire        REF_CLK,
  input  wire        RST_N,
  input  wire        SAFETY_IN_CH1,
  input  wire        SAFETY_IN_CH2,
  input  wire        ACTUATOR_PRESENT,
  input  wire        DEVICE_READY,
  input  wire        DEVICE_FAULT,
  input  wire        DIAG_MODULE_ATTACHED,
  input  wire        DIAG_IN,
  input  wire [15:0] TEACH_LEFT,
  input  wire [15:0] ACTUATOR_NAME,
  output reg         SAFE_OUT_CH1,
  output reg         SAFE_OUT_CH2,
  output reg         STATUS_DIAG_OUT,
  output reg  [1:0]  INPUT_LED,
  output reg         UNEQUAL_FLAG,
  output reg         PLAUS_ERROR,
  output wire        NAME_REFRESH
);
  // two stage synchronisers for the pin inputs
  reg [1:0] s1_r;
  reg [1:0] s2_r;
  reg [1:0] dm_r;
  reg [1:0] dg_r;

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      dm_r <= 2'h0;
      dg_r <= 2'h0;
    end else begin
      s1_r <= {s1_r[0], SAFETY_IN_CH1};
      s2_r <= {s2_r[0], SAFETY_IN_CH2};
      dm_r <= {dm_r[0], DIAG_MODULE_ATTACHED};
      dg_r <= {dg_r[0], DIAG_IN};
    end
  end

  wire in1 = s1_r[1];
  wire in2 = s2_r[1];
  wire link_en = dm_r[1];

  // previous values for edge detection
  reg in1_q_r;
  reg in2_q_r;
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      in1_q_r <= 1'b0;
      in2_q_r <= 1'b0;
    end else begin
      in1_q_r <= in1;
      in2_q_r <= in2;
    end
  end

  wire fall1 = in1_q_r & ~in1;
  wire fall2 = in2_q_r & ~in2;
  wire rise1 = ~in1_q_r & in1;
  wire rise2 = ~in2_q_r & in2;

  // plausibility monitor; lock holds both outputs off until both low
  reg [1:0] pl_r;
  reg [1:0] pl_nxt;
  reg       uneq_ch_r;
  reg       uneq_ch_nxt;

  always @* begin
    pl_nxt      = pl_r;
    uneq_ch_nxt = uneq_ch_r;
    case (pl_r)
      `DCIL_PL_OK: begin
        if (fall1 && in2 && !fall2) begin
          pl_nxt      = `DCIL_PL_UNEQ;
          uneq_ch_nxt = 1'b0;
        end else if (fall2 && in1 && !fall1) begin
          pl_nxt      = `DCIL_PL_UNEQ;
          uneq_ch_nxt = 1'b1;
        end
      end
      `DCIL_PL_UNEQ: begin
        if (!in1 && !in2) begin
          pl_nxt = `DCIL_PL_OK;
        end else if ((!uneq_ch_r && rise1 && in2) ||
                     (uneq_ch_r && rise2 && in1)) begin
          pl_nxt = `DCIL_PL_LOCK;
        end
      end
      `DCIL_PL_LOCK: begin
        if (!in1 && !in2) begin
          pl_nxt = `DCIL_PL_OK;
        end
      end
      default: pl_nxt = `DCIL_PL_OK;
    endcase
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pl_r      <= `DCIL_PL_OK;
      uneq_ch_r <= 1'b0;
    end else begin
      pl_r      <= pl_nxt;
      uneq_ch_r <= uneq_ch_nxt;
    end
  end

  // outputs; the link reaches only STATUS_DIAG_OUT here, so it cannot alter the safe outputs
  wire run_ok = DEVICE_READY & ~DEVICE_FAULT;
  // next state, so the offending rise never reaches the outputs
  wire locked = (pl_nxt == `DCIL_PL_LOCK);

  wire        link_tx;
  wire        link_act;
  wire [15:0] status_word = {8'h00, NODE_ADDR, pl_r, SAFE_OUT_CH2, SAFE_OUT_CH1};

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SAFE_OUT_CH1    <= 1'b0;
      SAFE_OUT_CH2    <= 1'b0;
      STATUS_DIAG_OUT <= 1'b0;
      INPUT_LED       <= `DCIL_IND_OFF;
      UNEQUAL_FLAG    <= 1'b0;
      PLAUS_ERROR     <= 1'b0;
    end else begin
      if (run_ok && ACTUATOR_PRESENT && !locked) begin
        SAFE_OUT_CH1 <= in1;
        SAFE_OUT_CH2 <= in2;
      end else begin
        SAFE_OUT_CH1 <= 1'b0;
        SAFE_OUT_CH2 <= 1'b0;
      end
      if (!ACTUATOR_PRESENT) begin
        STATUS_DIAG_OUT <= 1'b0;
      end else if (link_en && link_act) begin
        STATUS_DIAG_OUT <= link_tx;
      end else begin
        STATUS_DIAG_OUT <= 1'b1;
      end
      UNEQUAL_FLAG <= (pl_nxt == `DCIL_PL_UNEQ);
      PLAUS_ERROR  <= (pl_nxt == `DCIL_PL_LOCK);
      if (pl_nxt != `DCIL_PL_OK) begin
        INPUT_LED <= `DCIL_IND_FLASH;
      end else if (in1 || in2) begin
        INPUT_LED <= `DCIL_IND_ON;
      end else begin
        INPUT_LED <= `DCIL_IND_OFF;
      end
    end
  end

  // link restarts from idle on every reset, i.e. each power-up
  dcil_diag_link #(
    .NODE_ADDR  (NODE_ADDR),
    .BIT_CYCLES (BIT_CYCLES)
  ) u_link (
    .clk           (REF_CLK),
    .rst_n         (RST_N),
    .enable        (link_en),
    .rx            (dg_r[1]),
    .status_word   (status_word),
    .teach_left    (TEACH_LEFT),
    .serial_no     (SERIAL_NO),
    .actuator_name (ACTUATOR_NAME),
    .tx            (link_tx),
    .tx_active     (link_act),
    .name_refresh  (NAME_REFRESH)
  );
endmodule // dcil_top

/* File: dcil_top_sva.sv */
// port assertions for the interlock top
// assumes pins are held several cycles between changes
`timescale 1ns/100ps
module dcil_top_sva (
  input wire       REF_CLK,
  input wire       RST_N,
  input wire       SAFETY_IN_CH1,
  input wire       SAFETY_IN_CH2,
  input wire       ACTUATOR_PRESENT,
  input wire       DEVICE_READY,
  input wire       DEVICE_FAULT,
  input wire       DIAG_MODULE_ATTACHED,
  input wire       SAFE_OUT_CH1,
  input wire       SAFE_OUT_CH2,
  input wire       STATUS_DIAG_OUT,
  input wire [1:0] INPUT_LED,
  input wire       UNEQUAL_FLAG,
  input wire       PLAUS_ERROR,
  input wire       NAME_REFRESH
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  wire hi2 = SAFETY_IN_CH1 && SAFETY_IN_CH2;
  wire run = ACTUATOR_PRESENT && DEVICE_READY && !DEVICE_FAULT;
  property p_off; !ACTUATOR_PRESENT [*4] |-> !SAFE_OUT_CH1 && !SAFE_OUT_CH2 && !STATUS_DIAG_OUT; endproperty
  a_off: assert property (p_off) else $error("outputs on without actuator");
  property p_safe; (DEVICE_FAULT || !DEVICE_READY) [*2] |-> !SAFE_OUT_CH1 && !SAFE_OUT_CH2; endproperty
  a_safe: assert property (p_safe) else $error("outputs on while not ready");
  property p_fol; (run && !PLAUS_ERROR && $stable(SAFETY_IN_CH1) && $stable(SAFETY_IN_CH2)) [*5]
    |-> SAFE_OUT_CH1 == SAFETY_IN_CH1 && SAFE_OUT_CH2 == SAFETY_IN_CH2; endproperty
  a_fol: assert property (p_fol) else $error("outputs do not follow inputs");
  property p_stat; (!DIAG_MODULE_ATTACHED && $stable(ACTUATOR_PRESENT)) [*6] |-> STATUS_DIAG_OUT == ACTUATOR_PRESENT; endproperty
  a_stat: assert property (p_stat) else $error("status differs from actuator");
  property p_uneq; (hi2 && !PLAUS_ERROR) [*4] ##1 (!SAFETY_IN_CH1 && SAFETY_IN_CH2) [*4]
    |-> UNEQUAL_FLAG && INPUT_LED == 2'h2; endproperty
  a_uneq: assert property (p_uneq) else $error("unequal inputs not flagged");
  property p_lock; (hi2 && !PLAUS_ERROR) [*4] ##1 (!SAFETY_IN_CH1 && SAFETY_IN_CH2) [*4] ##1 hi2 [*4]
    |-> PLAUS_ERROR && !SAFE_OUT_CH1 && !SAFE_OUT_CH2 && INPUT_LED == 2'h2; endproperty
  a_lock: assert property (p_lock) else $error("no lock after plausibility error");
  property p_free; PLAUS_ERROR ##0 (!SAFETY_IN_CH1 && !SAFETY_IN_CH2) [*5] |-> !PLAUS_ERROR; endproperty
  a_free: assert property (p_free) else $error("lock kept with both inputs low");
  property p_idle; !DIAG_MODULE_ATTACHED [*6] |-> !NAME_REFRESH; endproperty
  a_idle: assert property (p_idle) else $error("link acted while detached");
endmodule // dcil_top_sva
bind dcil_top dcil_top_sva dcil_top_sva_i (.REF_CLK, .RST_N, .SAFETY_IN_CH1, .SAFETY_IN_CH2, .ACTUATOR_PRESENT,
  .DEVICE_READY, .DEVICE_FAULT, .DIAG_MODULE_ATTACHED, .SAFE_OUT_CH1, .SAFE_OUT_CH2, .STATUS_DIAG_OUT,
  .INPUT_LED, .UNEQUAL_FLAG, .PLAUS_ERROR, .NAME_REFRESH);

/* File: dcil_fb_model.sv */
// fieldbus module model: sends one query frame, looks for the answer
// assumes the sensor answers on the status line within 300 cycles
`timescale 1ns/100ps
module dcil_fb_model #(
  parameter int BITC = 4
) (
  input  wire  clk,
  input  wire  status_in,
  output logic diag_in
);
  logic s [0:299];
  initial diag_in = 1'b0;
  // frame bits 15:12 node address 0 to 15, bits 11:8 command
  task automatic query(input logic [15:0] frame, input logic [15:0] expw, output bit hit);
    bit ok;
    hit = 1'b0;
    for (int i = 0; i < 17 * BITC; i++) begin
      @(negedge clk);
      diag_in = (i < BITC) ? 1'b1 : frame[16 - i / BITC];
    end
    @(negedge clk);
    diag_in = 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      #1 s[i] = status_in;
    end
    // answer start is not fixed, so slide over every offset
    for (int k = 0; k < 300 - 16 * BITC; k++) begin
      ok = 1'b1;
      for (int j = 0; j < 16; j++) if (s[k + j * BITC] !== expw[15 - j]) ok = 1'b0;
      if (ok) hit = 1'b1;
    end
  endtask
endmodule // dcil_fb_model

/* File: tb.sv */
// self-checking bench for the interlock top
// assumes checker and fieldbus model are compiled first
`timescale 1ns/100ps
module tb;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       in1 = 1'b0;
  logic       in2 = 1'b0;
  logic       act = 1'b0;
  logic       rdy = 1'b0;
  logic       flt = 1'b0;
  logic       att = 1'b0;
  wire        diag, out1, out2, stat, uneq, perr, nref;
  wire  [1:0] led;
  int         error_cnt = 0;
  int         n_checks = 0;
  int         nref_cnt = 0;
  bit         hit;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (nref === 1'b1) nref_cnt++;
  dcil_top #(.NODE_ADDR(4'hF), .BIT_CYCLES(16'h0004)) dcil_top_i (.REF_CLK(ref_clk), .RST_N(rst_n),
    .SAFETY_IN_CH1(in1), .SAFETY_IN_CH2(in2), .ACTUATOR_PRESENT(act), .DEVICE_READY(rdy), .DEVICE_FAULT(flt),
    .DIAG_MODULE_ATTACHED(att), .DIAG_IN(diag), .TEACH_LEFT(16'hA5C3), .ACTUATOR_NAME(16'h3C5A),
    .SAFE_OUT_CH1(out1), .SAFE_OUT_CH2(out2), .STATUS_DIAG_OUT(stat), .INPUT_LED(led),
    .UNEQUAL_FLAG(uneq), .PLAUS_ERROR(perr), .NAME_REFRESH(nref));
  dcil_fb_model #(.BITC(4)) dcil_fb_model_i (.clk(ref_clk), .status_in(stat), .diag_in(diag));
  task automatic chk(input string nm, input logic [1:0] ex, input logic [1:0] got);
    n_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic drive(input logic [1:0] v);
    @(negedge ref_clk);
    {in1, in2} = v;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic t_truth();
    logic [1:0] seq [6] = '{2'h3, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0};
    foreach (seq[i]) begin
      drive(seq[i]);
      chk("safe outputs", seq[i], {out1, out2});
      chk("status", 2'h1, {1'b0, stat});
    end
    act = 1'b0;
    drive(2'h3);
    chk("safe outputs", 2'h0, {out1, out2});
    chk("status", 2'h0, {1'b0, stat});
    act = 1'b1;
    dcil_fb_model_i.query(16'hF200, 16'hA5C3, hit);
    chk("detached reply", 2'h0, {1'b0, hit});
    $display("test truth table done");
  endtask
  task automatic t_fault();
    flt = 1'b1;
    drive(2'h3);
    chk("safe outputs", 2'h0, {out1, out2});
    flt = 1'b0;
    rdy = 1'b0;
    drive(2'h3);
    chk("safe outputs", 2'h0, {out1, out2});
    rdy = 1'b1;
    drive(2'h3);
    chk("safe outputs", 2'h3, {out1, out2});
    $display("test fault done");
  endtask
  task automatic t_plaus();
    drive(2'h1);
    chk("unequal flag", 2'h1, {1'b0, uneq});
    chk("input led", 2'h2, led);
    chk("safe outputs", 2'h1, {out1, out2});
    drive(2'h3);
    chk("lock", 2'h1, {1'b0, perr});
    chk("safe outputs", 2'h0, {out1, out2});
    chk("input led", 2'h2, led);
    drive(2'h1);
    chk("lock", 2'h1, {1'b0, perr});
    chk("safe outputs", 2'h0, {out1, out2});
    drive(2'h0);
    chk("lock", 2'h0, {1'b0, perr});
    chk("input led", 2'h0, led);
    drive(2'h3);
    chk("safe outputs", 2'h3, {out1, out2});
    chk("input led", 2'h1, led);
    drive(2'h2);
    chk("unequal flag", 2'h1, {1'b0, uneq});
    chk("safe outputs", 2'h2, {out1, out2});
    drive(2'h3);
    chk("lock", 2'h1, {1'b0, perr});
    chk("safe outputs", 2'h0, {out1, out2});
    drive(2'h0);
    chk("lock", 2'h0, {1'b0, perr});
    drive(2'h3);
    chk("safe outputs", 2'h3, {out1, out2});
    $display("test plausibility done");
  endtask
  task automatic t_link();
    att = 1'b1;
    repeat (4) @(negedge ref_clk);
    dcil_fb_model_i.query(16'hF200, 16'hA5C3, hit);
    chk("teach reply", 2'h1, {1'b0, hit});
    dcil_fb_model_i.query(16'hF100, 16'h00F3, hit);
    chk("status reply", 2'h1, {1'b0, hit});
    dcil_fb_model_i.query(16'hF300, 16'h0001, hit);
    chk("serial reply", 2'h1, {1'b0, hit});
    dcil_fb_model_i.query(16'hF400, 16'h3C5A, hit);
    chk("name reply", 2'h1, {1'b0, hit});
    chk("name refresh", 2'h1, nref_cnt[1:0]);
    dcil_fb_model_i.query(16'h0200, 16'hA5C3, hit);
    chk("other node reply", 2'h0, {1'b0, hit});
    chk("safe outputs", 2'h3, {out1, out2});
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    dcil_fb_model_i.query(16'hF200, 16'hA5C3, hit);
    chk("teach after reset", 2'h1, {1'b0, hit});
    chk("safe outputs", 2'h3, {out1, out2});
    $display("test link done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    act = 1'b1;
    rdy = 1'b1;
    t_truth();
    t_fault();
    t_plaus();
    t_link();
    complete_run();
  end
  // seven link queries of about 400 cycles dominate, so 20000 is ample
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    complete_run();
  end
endmodule // tb
